// *** hdl/pwm2_timer_pkg.sv ***
package pwm2_timer_pkg;

    // ========================================
    // register indices (byte address is index times four)
    localparam logic [9:0] IDX_MODE  = 10'h120;
    localparam logic [9:0] IDX_CTRL1 = 10'h121;
    localparam logic [9:0] IDX_IER   = 10'h122;
    localparam logic [9:0] IDX_STAT  = 10'h123;
    localparam logic [9:0] IDX_COUNT = 10'h124;
    localparam logic [9:0] IDX_GRA   = 10'h128;
    localparam logic [9:0] IDX_GRB   = 10'h129;
    localparam logic [9:0] IDX_GRC   = 10'h12A;
    localparam logic [9:0] IDX_GRD   = 10'h12B;
    localparam logic [9:0] IDX_CTRL2 = 10'h130;
    localparam logic [9:0] IDX_FILT  = 10'h131;

    // ========================================
    // field positions
    localparam int MODE_RUN      = 0;
    localparam int MODE_BFD      = 5;
    localparam int CTRL1_TOB     = 1;
    localparam int CTRL1_CKS_LSB = 4;
    localparam int CTRL1_CLEAR_ON_PERIOD_BIT    = 7;
    localparam int CTRL2_STOP_ON_PERIOD_BIT    = 5;
    localparam int CTRL2_EDG_LSB = 6;
    localparam int FILT_TRG      = 4;
    localparam int FILT_CK_LSB   = 6;

    // ========================================
    // reset values and fixed read bits
    localparam logic [7:0]  MODE_RST   = 8'h00;
    localparam logic [7:0]  CTRL1_RST  = 8'h00;
    localparam logic [7:0]  CTRL2_RST  = 8'h18;
    localparam logic [7:0]  CTRL2_ONES = 8'h18;
    localparam logic [7:0]  FILT_RST   = 8'h00;
    localparam logic [7:0]  FILT_MASK  = 8'hDF;
    localparam logic [3:0]  IER_RST    = 4'h0;
    localparam logic [15:0] GR_RST     = 16'hFFFF;
    localparam logic [15:0] CNT_MAX    = 16'hFFFF;

    // ========================================
    // count source, filter clock and trigger edge encodings
    localparam logic [2:0] CKS_F1   = 3'h0;
    localparam logic [2:0] CKS_F2   = 3'h1;
    localparam logic [2:0] CKS_F4   = 3'h2;
    localparam logic [2:0] CKS_F8   = 3'h3;
    localparam logic [2:0] CKS_F32  = 3'h4;
    localparam logic [2:0] CKS_EXT  = 3'h5;
    localparam logic [2:0] CKS_O40M = 3'h6;
    localparam logic [2:0] CKS_OF   = 3'h7;
    localparam logic [1:0] FCK_F32  = 2'h0;
    localparam logic [1:0] FCK_F8   = 2'h1;
    localparam logic [1:0] FCK_F1   = 2'h2;
    localparam logic [1:0] EDG_OFF  = 2'h0;
    localparam logic [1:0] EDG_RISE = 2'h1;
    localparam logic [1:0] EDG_FALL = 2'h2;

    // ========================================
    // types
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_RUN  = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic ovf;
        logic c;
        logic b;
        logic a;
    } cmp_evt_t;

endpackage

// *** hdl/wait_oneshot_pwm_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module wait_oneshot_pwm_timer #(
    parameter int CNT_W = 16
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // avalon-mm slave
    input  wire logic [11:0] address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic      [31:0] readdata_o,
    output logic             waitrequest_o,
    // pins and clock sources
    input  wire logic        trigger_in_pin_i,
    input  wire logic        ext_count_clk_pin_i,
    input  wire logic        fast_osc_40m_clk_i,
    input  wire logic        fast_osc_f_clk_i,
    // waveform and interrupt
    output logic             pwm_out_pin_b_o,
    output logic             irq_o
);

    // ========================================
    // bus handshake: one wait cycle per access
    logic                         wait_q;
    logic                         req;
    logic                         wr;
    logic [9:0]                   idx;
    logic [31:0]                  rdata_q;

    assign req = read_i | write_i;
    assign wr  = write_i & ~wait_q;
    assign idx = address_i[11:2];

    // waitrequest drops for one cycle after a request is seen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(req & wait_q);
        end
    end

    // ========================================
    // registers
    logic [7:0]                   mode_q;
    logic [7:0]                   ctrl1_q;
    logic [7:0]                   ctrl2_q;
    logic [7:0]                   filt_q;
    logic [3:0]                   ier_q;
    logic [3:0]                   stat_q;
    logic [CNT_W-1:0]             cnt_q;
    logic [CNT_W-1:0]             gra_q;
    logic [CNT_W-1:0]             grb_q;
    logic [CNT_W-1:0]             grc_q;
    logic [CNT_W-1:0]             grd_q;
    logic [CNT_W-1:0]             wr16;
    pwm2_timer_pkg::cmp_evt_t     evt;

    // byte-lane merge for 16-bit registers
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = d[7:0];
        end
        if (be[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    // control, enable and compare A, C and D register writes (GRB is written in the sequencer block)
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q  <= pwm2_timer_pkg::MODE_RST;
            ctrl1_q <= pwm2_timer_pkg::CTRL1_RST;
            ctrl2_q <= pwm2_timer_pkg::CTRL2_RST;
            filt_q  <= pwm2_timer_pkg::FILT_RST;
            ier_q   <= pwm2_timer_pkg::IER_RST;
            gra_q   <= pwm2_timer_pkg::GR_RST;
            grc_q   <= pwm2_timer_pkg::GR_RST;
            grd_q   <= pwm2_timer_pkg::GR_RST;
        end else if (wr && byteenable_i[0]) begin
            case (idx)
                pwm2_timer_pkg::IDX_MODE:  mode_q  <= writedata_i[7:0];
                pwm2_timer_pkg::IDX_CTRL1: ctrl1_q <= writedata_i[7:0];
                pwm2_timer_pkg::IDX_CTRL2: ctrl2_q <= writedata_i[7:0] | pwm2_timer_pkg::CTRL2_ONES;
                pwm2_timer_pkg::IDX_FILT:  filt_q  <= writedata_i[7:0] & pwm2_timer_pkg::FILT_MASK;
                pwm2_timer_pkg::IDX_IER:   ier_q   <= writedata_i[3:0];
                pwm2_timer_pkg::IDX_GRA:   gra_q   <= merge16(gra_q, writedata_i, byteenable_i);
                pwm2_timer_pkg::IDX_GRC:   grc_q   <= merge16(grc_q, writedata_i, byteenable_i);
                pwm2_timer_pkg::IDX_GRD:   grd_q   <= merge16(grd_q, writedata_i, byteenable_i);
                default: ;
            endcase
        end
    end

    // decoded control fields
    logic                         run_bit;
    logic                         bfd_bit;
    logic                         tob_bit;
    logic                         clear_on_period_bit_bit;
    logic [2:0]                   cks;
    logic                         stop_on_period_bit_bit;
    logic [1:0]                   edg;
    logic                         trig_mode;

    assign run_bit   = mode_q[pwm2_timer_pkg::MODE_RUN];
    assign bfd_bit   = mode_q[pwm2_timer_pkg::MODE_BFD];
    assign tob_bit   = ctrl1_q[pwm2_timer_pkg::CTRL1_TOB];
    assign clear_on_period_bit_bit  = ctrl1_q[pwm2_timer_pkg::CTRL1_CLEAR_ON_PERIOD_BIT];
    assign cks       = ctrl1_q[pwm2_timer_pkg::CTRL1_CKS_LSB +: 3];
    assign stop_on_period_bit_bit  = ctrl2_q[pwm2_timer_pkg::CTRL2_STOP_ON_PERIOD_BIT];
    assign edg       = ctrl2_q[pwm2_timer_pkg::CTRL2_EDG_LSB +: 2];
    assign trig_mode = (edg != pwm2_timer_pkg::EDG_OFF) && stop_on_period_bit_bit;

    // ========================================
    // pin synchronisers and prescaler
    logic [1:0]                   ext_s_q;
    logic [1:0]                   o40_s_q;
    logic [1:0]                   of_s_q;
    logic [1:0]                   trg_s_q;
    logic                         ext_d_q;
    logic                         o40_d_q;
    logic                         of_d_q;
    logic [4:0]                   pre_q;

    // two flops per asynchronous input, third flop for edge detect on the three count clock inputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_s_q <= 2'h0;
            o40_s_q <= 2'h0;
            of_s_q  <= 2'h0;
            trg_s_q <= 2'h0;
            ext_d_q <= 1'b0;
            o40_d_q <= 1'b0;
            of_d_q  <= 1'b0;
        end else begin
            ext_s_q <= {ext_s_q[0], ext_count_clk_pin_i};
            o40_s_q <= {o40_s_q[0], fast_osc_40m_clk_i};
            of_s_q  <= {of_s_q[0], fast_osc_f_clk_i};
            trg_s_q <= {trg_s_q[0], trigger_in_pin_i};
            ext_d_q <= ext_s_q[1];
            o40_d_q <= o40_s_q[1];
            of_d_q  <= of_s_q[1];
        end
    end

    // free-running divider for f2 to f32 enables
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= 5'h00;
        end else begin
            pre_q <= pre_q + 5'h01;
        end
    end

    // count clock select as one-cycle enable
    logic                         tick;
    logic                         en_f8;
    logic                         en_f32;

    assign en_f8  = &pre_q[2:0];
    assign en_f32 = &pre_q;

    always_comb begin
        case (cks)
            pwm2_timer_pkg::CKS_F1:   tick = 1'b1;
            pwm2_timer_pkg::CKS_F2:   tick = pre_q[0];
            pwm2_timer_pkg::CKS_F4:   tick = &pre_q[1:0];
            pwm2_timer_pkg::CKS_F8:   tick = en_f8;
            pwm2_timer_pkg::CKS_F32:  tick = en_f32;
            pwm2_timer_pkg::CKS_EXT:  tick = ext_s_q[1] & ~ext_d_q;
            pwm2_timer_pkg::CKS_O40M: tick = o40_s_q[1] & ~o40_d_q;
            pwm2_timer_pkg::CKS_OF:   tick = of_s_q[1] & ~of_d_q;
            default:                  tick = 1'b0;
        endcase
    end

    // ========================================
    // trigger digital filter and edge detect
    logic                         fck;
    logic [2:0]                   fsh_q;
    logic                         flt_q;
    logic                         trg_lvl;
    logic                         trg_prev_q;
    logic                         trig_edge;

    always_comb begin
        case (filt_q[pwm2_timer_pkg::FILT_CK_LSB +: 2])
            pwm2_timer_pkg::FCK_F32: fck = en_f32;
            pwm2_timer_pkg::FCK_F8:  fck = en_f8;
            pwm2_timer_pkg::FCK_F1:  fck = 1'b1;
            default:                 fck = tick;
        endcase
    end

    // level accepted after three equal samples
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fsh_q <= 3'h0;
            flt_q <= 1'b0;
        end else if (fck) begin
            fsh_q <= {fsh_q[1:0], trg_s_q[1]};
            if (fsh_q == 3'h7) begin
                flt_q <= 1'b1;
            end else if (fsh_q == 3'h0) begin
                flt_q <= 1'b0;
            end
        end
    end

    assign trg_lvl = filt_q[pwm2_timer_pkg::FILT_TRG] ? flt_q : trg_s_q[1];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trg_prev_q <= 1'b0;
        end else begin
            trg_prev_q <= trg_lvl;
        end
    end

    always_comb begin
        case (edg)
            pwm2_timer_pkg::EDG_RISE: trig_edge = trg_lvl & ~trg_prev_q;
            pwm2_timer_pkg::EDG_FALL: trig_edge = ~trg_lvl & trg_prev_q;
            pwm2_timer_pkg::EDG_OFF:  trig_edge = 1'b0;
            default:                  trig_edge = trg_lvl ^ trg_prev_q;
        endcase
    end

    // ========================================
    // count sequencer and waveform
    pwm2_timer_pkg::seq_state_t   state_q;
    logic                         pwm_q;
    logic                         wr_mode;
    logic                         wr_cnt;
    logic                         restart;
    logic                         run_tick;
    logic                         clr_now;

    assign wr_mode  = wr && byteenable_i[0] && (idx == pwm2_timer_pkg::IDX_MODE);
    assign wr_cnt   = wr && (idx == pwm2_timer_pkg::IDX_COUNT);
    assign restart  = (state_q == pwm2_timer_pkg::ST_RUN) && trig_mode && trig_edge && !wr_mode;
    assign run_tick = (state_q == pwm2_timer_pkg::ST_RUN) && tick && !wr_mode && !restart;
    assign clr_now  = evt.a && (clear_on_period_bit_bit || stop_on_period_bit_bit) && clear_on_period_bit_bit;
    assign wr16     = merge16(cnt_q, writedata_i, byteenable_i);

    // compare events on the counted value
    always_comb begin
        evt.a   = run_tick && (cnt_q == gra_q);
        evt.b   = run_tick && (cnt_q == grb_q);
        evt.c   = run_tick && (cnt_q == grc_q);
        evt.ovf = run_tick && (cnt_q == pwm2_timer_pkg::CNT_MAX);
    end

    // one engine for the state, counter, end point and pin level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= pwm2_timer_pkg::ST_IDLE;
            cnt_q   <= '0;
            grb_q   <= pwm2_timer_pkg::GR_RST;
            pwm_q   <= 1'b0;
        end else begin
            if (wr && byteenable_i[0] && (idx == pwm2_timer_pkg::IDX_CTRL1)) begin
                pwm_q <= writedata_i[pwm2_timer_pkg::CTRL1_TOB];
            end
            if (wr && (idx == pwm2_timer_pkg::IDX_GRB)) begin
                grb_q <= merge16(grb_q, writedata_i, byteenable_i);
            end
            if (wr_mode) begin
                if (!writedata_i[pwm2_timer_pkg::MODE_RUN]) begin
                    state_q <= pwm2_timer_pkg::ST_IDLE;
                    pwm_q   <= tob_bit;
                end else if (state_q == pwm2_timer_pkg::ST_IDLE) begin
                    state_q <= trig_mode ? pwm2_timer_pkg::ST_WAIT : pwm2_timer_pkg::ST_RUN;
                    pwm_q   <= tob_bit;
                end
            end else begin
                case (state_q)
                    pwm2_timer_pkg::ST_WAIT: begin
                        pwm_q <= tob_bit;
                        if (trig_edge) begin
                            cnt_q   <= '0;
                            state_q <= pwm2_timer_pkg::ST_RUN;
                        end
                    end
                    pwm2_timer_pkg::ST_RUN: begin
                        if (restart) begin
                            cnt_q <= '0;
                            pwm_q <= tob_bit;
                        end else if (run_tick) begin
                            cnt_q <= cnt_q + CNT_W'(1);
                            if (evt.c) begin
                                pwm_q <= ~tob_bit;
                            end
                            if (evt.b) begin
                                pwm_q <= tob_bit;
                            end
                            if (evt.a) begin
                                if (bfd_bit) begin
                                    grb_q <= grd_q;
                                end
                                if (clear_on_period_bit_bit) begin
                                    cnt_q <= '0;
                                end
                                if (stop_on_period_bit_bit) begin
                                    pwm_q   <= tob_bit;
                                    cnt_q   <= clear_on_period_bit_bit ? '0 : cnt_q;
                                    state_q <= trig_mode ? pwm2_timer_pkg::ST_WAIT : pwm2_timer_pkg::ST_IDLE;
                                end
                            end
                        end
                    end
                    pwm2_timer_pkg::ST_IDLE: ;
                    default: state_q <= pwm2_timer_pkg::ST_IDLE;
                endcase
            end
            if (wr_cnt && !clr_now) begin
                cnt_q <= wr16;
            end
        end
    end

    // ========================================
    // status flags and interrupt request
    logic [3:0]                   stat_keep;
    logic [3:0]                   stat_d;

    // write 0 clears a flag; a new event wins over the clear
    always_comb begin
        stat_keep = stat_q;
        if (wr && byteenable_i[0] && (idx == pwm2_timer_pkg::IDX_STAT)) begin
            stat_keep = stat_q & writedata_i[3:0];
        end
        stat_d = stat_keep | evt;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stat_q <= 4'h0;
            irq_o  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_o  <= |(stat_d & ier_q);
        end
    end

    // ========================================
    // read data mux and waveform pin
    logic [31:0]                  rmux;

    always_comb begin
        rmux = 32'h0000_0000;
        case (idx)
            pwm2_timer_pkg::IDX_MODE:  rmux[7:0]  = mode_q;
            pwm2_timer_pkg::IDX_CTRL1: rmux[7:0]  = ctrl1_q;
            pwm2_timer_pkg::IDX_CTRL2: rmux[7:0]  = ctrl2_q | pwm2_timer_pkg::CTRL2_ONES;
            pwm2_timer_pkg::IDX_FILT:  rmux[7:0]  = filt_q & pwm2_timer_pkg::FILT_MASK;
            pwm2_timer_pkg::IDX_IER:   rmux[3:0]  = ier_q;
            pwm2_timer_pkg::IDX_STAT:  rmux[3:0]  = stat_q;
            pwm2_timer_pkg::IDX_COUNT: rmux[15:0] = cnt_q;
            pwm2_timer_pkg::IDX_GRA:   rmux[15:0] = gra_q;
            pwm2_timer_pkg::IDX_GRB:   rmux[15:0] = grb_q;
            pwm2_timer_pkg::IDX_GRC:   rmux[15:0] = grc_q;
            pwm2_timer_pkg::IDX_GRD:   rmux[15:0] = grd_q;
            default:                   rmux       = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (read_i && wait_q) begin
            rdata_q <= rmux;
        end
    end

    assign readdata_o      = rdata_q;
    assign waitrequest_o   = wait_q;
    assign pwm_out_pin_b_o = pwm_q;

endmodule

`default_nettype wire

// *** tb/pwm2_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checker
module pwm2_checker (
    // watched top-level ports
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [11:0] address_i,
    input wire logic        read_i,
    input wire logic        write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic        waitrequest_o,
    input wire logic        pwm_out_pin_b_o,
    input wire logic        irq_o
);
    // one clock domain, one reset
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic       rd;
    logic [9:0] idx;
    // answered read and register index
    assign rd  = read_i && !waitrequest_o;
    assign idx = address_i[11:2];
    a_wait_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("answer held past one cycle");
    a_wait_cause: assert property (!waitrequest_o |-> $past(read_i || write_i))
        else $error("answer without request");
    a_rdata_hold: assert property (!read_i ##1 !read_i |-> $stable(readdata_o))
        else $error("read data moved without read");
    a_ctrl2_ones: assert property (rd && idx == pwm2_timer_pkg::IDX_CTRL2 |-> readdata_o[4:3] == 2'h3)
        else $error("control two fixed bits not one");
    a_filt_zero: assert property (rd && idx == pwm2_timer_pkg::IDX_FILT |-> !readdata_o[5])
        else $error("filter bit five not zero");
    a_unmapped_zero: assert property (rd && idx == 10'h000 |-> readdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl1_level: assert property (write_i && !waitrequest_o && idx == pwm2_timer_pkg::IDX_CTRL1
        |-> ##2 pwm_out_pin_b_o == $past(writedata_i[1], 2))
        else $error("initial level not driven");
    // main scenarios reached
    c_read: cover property (rd);
    c_pwm_rise: cover property ($rose(pwm_out_pin_b_o));
    c_irq_rise: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// *** tb/pwm2_far_side.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// trigger source and count clock sources
module pwm2_far_side (
    // clock and trigger request
    input  wire logic clk_i,
    input  wire logic fire_i,
    // lines toward the timer
    output logic      trig_o,
    output logic      ext_clk_o,
    output logic      osc40_o,
    output logic      oscf_o
);
    int cnt_q;
    initial begin
        cnt_q = 0;
        trig_o = 1'b0;
    end
    // each request flips the trigger line: rise, fall, rise
    always @(posedge clk_i) begin
        cnt_q <= cnt_q + 1;
        if (fire_i) begin
            trig_o <= ~trig_o;
        end
    end
    // free-running sources, periods of 6, 4 and 6 clocks
    assign ext_clk_o = (cnt_q % 6) < 3;
    assign osc40_o   = (cnt_q % 4) < 2;
    assign oscf_o    = (cnt_q % 6) < 3;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
// ========================================
// top bench
module testbench;
    typedef struct {logic [2:0] cks; int hi; int lo;} row_t;
    logic        clk_i, rst_n_i, read_i, write_i, fire;
    logic [11:0] address_i;
    logic [31:0] writedata_i, q;
    wire logic [31:0] readdata_o;
    wire logic   wr, pwm, irq, trg, ext, o40, of;
    int          n_mismatch, n_compared, h, l;
    row_t        rows[8] = '{'{3'h0, 4, 6}, '{3'h1, 8, 12}, '{3'h2, 16, 24}, '{3'h3, 32, 48},
                            '{3'h4, 128, 192}, '{3'h5, 24, 36}, '{3'h6, 16, 24}, '{3'h7, 24, 36}};
    wait_oneshot_pwm_timer u_dut (.clk_i, .rst_n_i, .address_i, .read_i, .write_i, .writedata_i,
        .byteenable_i(4'hF), .readdata_o, .waitrequest_o(wr), .trigger_in_pin_i(trg),
        .ext_count_clk_pin_i(ext), .fast_osc_40m_clk_i(o40), .fast_osc_f_clk_i(of),
        .pwm_out_pin_b_o(pwm), .irq_o(irq));
    pwm2_far_side u_far (.clk_i, .fire_i(fire), .trig_o(trg), .ext_clk_o(ext), .osc40_o(o40), .oscf_o(of));
    // one bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [9:0] idx, input logic [15:0] d);
        address_i <= {idx, 2'h0};
        writedata_i <= {16'h0, d};
        read_i <= !w;
        write_i <= w;
        do begin
            @(posedge clk_i);
        end while (wr !== 1'b0);
        q = readdata_o;
        read_i <= 1'b0;
        write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // waits for level v, then counts clocks it lasts
    task automatic width(input logic v, output int w);
        int n;
        n = 0;
        w = 0;
        while (pwm !== v && n < 2000) begin
            @(negedge clk_i);
            n++;
        end
        while (pwm === v && w < 2000) begin
            @(negedge clk_i);
            w++;
        end
        @(posedge clk_i);
    endtask
    task end_of_test();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // watchdog
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst_n_i, read_i, write_i, fire, address_i, writedata_i, n_mismatch, n_compared} = '0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(0, pwm2_timer_pkg::IDX_CTRL1, 0); chk(q === 32'h0, "ctrl1 reset");
        bus(0, pwm2_timer_pkg::IDX_CTRL2, 0); chk(q[7:0] === 8'h18, "ctrl2 reset");
        bus(1, pwm2_timer_pkg::IDX_CTRL2, 16'h20); bus(0, pwm2_timer_pkg::IDX_CTRL2, 0);
        chk(q[7:0] === 8'h38, "ctrl2 fixed bits");
        bus(1, pwm2_timer_pkg::IDX_FILT, 16'hFF); bus(0, pwm2_timer_pkg::IDX_FILT, 0);
        chk(q[7:0] === 8'hDF, "filter fixed bit");
        bus(1, 10'h000, 16'hFF); bus(0, 10'h000, 0); chk(q === 32'h0, "unmapped");
        bus(1, pwm2_timer_pkg::IDX_COUNT, 16'h1234); bus(0, pwm2_timer_pkg::IDX_COUNT, 0);
        chk(q[15:0] === 16'h1234, "counter write");
        bus(1, pwm2_timer_pkg::IDX_COUNT, 0);
        bus(1, pwm2_timer_pkg::IDX_GRA, 9);
        bus(1, pwm2_timer_pkg::IDX_GRB, 6);
        bus(1, pwm2_timer_pkg::IDX_GRC, 2);
        bus(1, pwm2_timer_pkg::IDX_CTRL2, 0);
        bus(1, pwm2_timer_pkg::IDX_FILT, 0);
        $display("test registers done");
        // each count source: active and inactive widths
        foreach (rows[i]) begin
            bus(1, pwm2_timer_pkg::IDX_MODE, 0);
            bus(1, pwm2_timer_pkg::IDX_CTRL1, {1'b1, rows[i].cks, 4'h0});
            bus(1, pwm2_timer_pkg::IDX_MODE, 1);
            width(1, h); width(0, l); width(1, h);
            chk(h === rows[i].hi, "active width");
            chk(l === rows[i].lo, "inactive width");
        end
        $display("test sources done");
        bus(1, pwm2_timer_pkg::IDX_IER, 1); repeat (70) @(posedge clk_i);
        chk(irq === 1'b1, "irq raised");
        bus(1, pwm2_timer_pkg::IDX_MODE, 0); @(posedge clk_i);
        chk(pwm === 1'b0, "stop level");
        bus(0, pwm2_timer_pkg::IDX_STAT, 0); chk(q[0] === 1'b1, "period flag");
        bus(1, pwm2_timer_pkg::IDX_STAT, 0); @(posedge clk_i);
        chk(irq === 1'b0, "irq cleared");
        $display("test interrupt done");
        bus(1, pwm2_timer_pkg::IDX_CTRL1, 16'h82); @(posedge clk_i);
        chk(pwm === 1'b1, "inverted initial level");
        // rising, falling, both edges; filter on the last
        for (int e = 1; e < 4; e++) begin
            bus(1, pwm2_timer_pkg::IDX_MODE, 0);
            bus(1, pwm2_timer_pkg::IDX_CTRL2, {8'h0, e[1:0], 6'h20});
            bus(1, pwm2_timer_pkg::IDX_FILT, (e == 3) ? 16'h90 : 16'h0);
            bus(1, pwm2_timer_pkg::IDX_MODE, 1); repeat (20) @(posedge clk_i);
            chk(pwm === 1'b1, "idle before trigger");
            fire <= 1'b1; @(posedge clk_i); fire <= 1'b0;
            width(0, h); chk(h === 4, "triggered pulse");
            repeat (10) @(posedge clk_i); bus(0, pwm2_timer_pkg::IDX_COUNT, 0);
            chk(q[15:0] === 16'h0 && pwm === 1'b1, "stop on period");
        end
        $display("test trigger done");
        bus(1, pwm2_timer_pkg::IDX_MODE, 0);
        bus(1, pwm2_timer_pkg::IDX_GRD, 7); bus(1, pwm2_timer_pkg::IDX_MODE, 16'h21);
        fire <= 1'b1; @(posedge clk_i); fire <= 1'b0; repeat (40) @(posedge clk_i);
        bus(0, pwm2_timer_pkg::IDX_GRB, 0); chk(q[15:0] === 16'h7, "buffer reload");
        bus(0, pwm2_timer_pkg::IDX_STAT, 0); chk(q[2:0] === 3'h7, "compare flags");
        $display("test buffer done");
        end_of_test();
    end
endmodule
bind wait_oneshot_pwm_timer pwm2_checker u_chk (.clk_i, .rst_n_i, .address_i, .read_i, .write_i,
    .writedata_i, .readdata_o, .waitrequest_o, .pwm_out_pin_b_o, .irq_o);
`default_nettype wire
